// ==== src/ext_bus_consts.svh ====
// Constants for the external bus unit: address map, bus widths and clocking.
// Assumes nothing beyond a SystemVerilog compiler; definitions only.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

// Address map of bank 0.
`define REG_AREA_LO 16'h0000
`define REG_AREA_HI 16'h007f
`define RAM_AREA_LO 16'h0080
`define RAM_AREA_HI 16'h047f
`define RAM_BYTES 1024
`define RAM_INDEX_W 10
`define BANK_ZERO 8'h00

// Vector table which external memory must hold.
`define VECTOR_LO 16'hffdc
`define VECTOR_HI 16'hffff

// Widths.
`define ADDR_W 24
`define DATA_W 16
`define BANK_W 8
`define IP_W 16

// Clock output divides the core clock by this figure.
`define CLK_DIV 2

`endif

// ==== src/ext_bus_pkg.sv ====
// Types shared by the external bus unit, its memory model and its bench.
// Assumes the constants header is on the include path.
`include "ext_bus_consts.svh"

package ext_bus_pkg;

    // Bus cycle phases.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_WAIT,
        ST_DONE,
        ST_HOLD
    } bus_state_e;

    // Where an address lands.
    typedef enum logic [1:0] {
        AREA_REGS,
        AREA_RAM,
        AREA_EXT
    } area_e;

    // One access request from the core.
    typedef struct packed {
        logic write;
        logic word;
        logic fetch;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } bus_req_s;

    // Multiplexed pin group: output per lane, enable (low drives) for the middle and upper lanes.
    typedef struct packed {
        logic [7:0] lo_addr;
        logic [7:0] mid_out;
        logic [7:0] mid_oe_n;
        logic [7:0] hi_out;
        logic [7:0] hi_oe_n;
    } bus_pins_s;

endpackage : ext_bus_pkg

// ==== src/clk_halver.sv ====
// Clock output generator: a toggling flop giving the core clock over two.
// Assumes a single clock domain and the shared asynchronous reset.
`timescale 1ns/1ps
`include "ext_bus_consts.svh"

module clk_halver (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Divided clock, straight from a flop.
    output logic clk_out
);

    // The toggle flop divides by two; a counter would only be needed for larger ratios.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= ~clk_out;
        end
    end

    // The output must change on every rising clock edge out of reset.
    property p_toggles;
        @(posedge clk) disable iff (!arst_n) 1'b1 |=> (clk_out != $past(clk_out));
    endproperty
    a_toggles: assert property (p_toggles) else $error("Clock output failed to toggle.");

endmodule : clk_halver

// ==== src/ext_bus_unit.sv ====
// External bus unit: multiplexed address/data bus, strobes, ready and hold.
// Assumes core requests arrive synchronous to clk and pin inputs are asynchronous.
//
// Summary of operation
// - Width pin low means 16 bits, high 8.
// - Transfers happen only while bus strobe low.
// - Ready low stretches the bus cycle; the code ignores it in register and RAM area cycles.
// - Hold low makes device release the bus; the code releases only the middle and upper lanes, lo_addr stays driven.
// - Hold grant low exactly while in hold.
// - Read/write high for reads, low writes.
// - Upper byte strobe low on odd address.
// - Address latch strobe marks address phase.
// - 16-bit mode: middle lanes carry data high.
// - 16-bit mode: middle lanes carry address middle.
// - 8-bit mode: middle lanes carry only address.
// - Upper lanes carry data low while strobe low.
// - Upper lanes carry address high while strobe high.
// - Reset pin low resets the device.
// - Clock output is input clock halved.
// - Fetch address is code bank plus pointer.
// - Bank 0 low area is peripheral registers.
// - Bank 0 next area is internal RAM.
// - All other addresses go to external bus.
`timescale 1ns/1ps
`include "ext_bus_consts.svh"

module ext_bus_unit (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Core request side.
    input wire logic req_valid,
    input wire ext_bus_pkg::bus_req_s req,
    input wire logic [`BANK_W-1:0] code_bank,
    input wire logic [`IP_W-1:0] instr_pointer,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`DATA_W-1:0] rsp_rdata,
    output logic [1:0] rsp_area,
    // Bus pins.
    input wire logic width_sel,
    input wire logic ready_n,
    input wire logic hold_n,
    input wire logic [7:0] mid_in,
    input wire logic [7:0] hi_in,
    output ext_bus_pkg::bus_pins_s pins,
    output logic strobe_n,
    output logic addr_latch,
    output logic read_write,
    output logic upper_byte_strobe_n,
    output logic hold_grant_n,
    output logic clk_out
);

    // Two-flop synchronisers for the asynchronous pins.
    // Ready therefore reaches the state machine two cycles late; a slow memory must pull it
    // low as soon as it sees the address latch pulse, or the first wait state is missed.
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic byte_mode;
    logic ready_ok;
    logic hold_req;

    // Data lanes are not synchronised: they are sampled only while stable inside the strobe window.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {width_sel, ~ready_n, ~hold_n};
            sync_b <= sync_a;
        end
    end

    assign byte_mode = sync_b[2];
    assign ready_ok = ~sync_b[1];
    assign hold_req = sync_b[0];

    // Captured request and its decode.
    ext_bus_pkg::bus_state_e state;
    ext_bus_pkg::bus_req_s cur;
    ext_bus_pkg::area_e area;
    logic [`ADDR_W-1:0] eff_addr;
    ext_bus_pkg::area_e next_area;

    // Fetches take their address from the code bank and pointer.
    assign eff_addr = req.fetch ? {code_bank, instr_pointer} : req.addr;

    // Area decode of an incoming address.
    always_comb begin
        next_area = ext_bus_pkg::AREA_EXT;
        if (eff_addr[23:16] == `BANK_ZERO) begin
            if (eff_addr[15:0] <= `REG_AREA_HI) begin
                next_area = ext_bus_pkg::AREA_REGS;
            end else if (eff_addr[15:0] <= `RAM_AREA_HI) begin
                next_area = ext_bus_pkg::AREA_RAM;
            end
        end
    end

    // Internal RAM, flops addressed by index.
    logic [7:0] ram [`RAM_BYTES];
    logic [`RAM_INDEX_W-1:0] ram_idx;
    logic [`RAM_INDEX_W-1:0] ram_idx1;
    logic [15:0] ram_off;

    assign ram_off = cur.addr[15:0] - `RAM_AREA_LO;
    assign ram_idx = ram_off[`RAM_INDEX_W-1:0];
    assign ram_idx1 = ram_idx + `RAM_INDEX_W'(1);

    // RAM holds data and stack; written on the edge that ends ST_DATA, before ST_WAIT.
    always_ff @(posedge clk) begin
        if (state == ext_bus_pkg::ST_DATA && area == ext_bus_pkg::AREA_RAM && cur.write) begin
            ram[ram_idx] <= cur.wdata[7:0];
            if (cur.word) begin
                ram[ram_idx1] <= cur.wdata[15:8];
            end
        end
    end

    // Bus state machine; hold is honoured only between cycles.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ext_bus_pkg::ST_IDLE;
            cur <= '0;
            area <= ext_bus_pkg::AREA_EXT;
        end else begin
            case (state)
                ext_bus_pkg::ST_IDLE: begin
                    if (hold_req) begin
                        state <= ext_bus_pkg::ST_HOLD;
                    end else if (req_valid) begin
                        cur <= req;
                        cur.addr <= eff_addr;
                        area <= next_area;
                        state <= ext_bus_pkg::ST_ADDR;
                    end
                end
                ext_bus_pkg::ST_ADDR: state <= ext_bus_pkg::ST_DATA;
                ext_bus_pkg::ST_DATA: state <= ext_bus_pkg::ST_WAIT;
                ext_bus_pkg::ST_WAIT: begin
                    // Internal areas never wait on outside ready.
                    if (ready_ok || area != ext_bus_pkg::AREA_EXT) begin
                        state <= ext_bus_pkg::ST_DONE;
                    end
                end
                ext_bus_pkg::ST_DONE: state <= ext_bus_pkg::ST_IDLE;
                ext_bus_pkg::ST_HOLD: begin
                    if (!hold_req) begin
                        state <= ext_bus_pkg::ST_IDLE;
                    end
                end
                default: state <= ext_bus_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin outputs, all from flops; during hold the middle and upper lanes are released, lo_addr stays driven.
    logic data_phase;
    logic drive_data;
    assign data_phase = state == ext_bus_pkg::ST_DATA || state == ext_bus_pkg::ST_WAIT;
    assign drive_data = data_phase && cur.write;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_n <= 1'b1;
            addr_latch <= 1'b0;
            read_write <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            hold_grant_n <= 1'b1;
            pins <= '{lo_addr: 8'h00, mid_out: 8'h00, mid_oe_n: 8'hff, hi_out: 8'h00, hi_oe_n: 8'hff};
        end else begin
            hold_grant_n <= ~(state == ext_bus_pkg::ST_HOLD);
            strobe_n <= ~(state == ext_bus_pkg::ST_ADDR || data_phase);
            addr_latch <= (state == ext_bus_pkg::ST_IDLE && req_valid && !hold_req);
            read_write <= ~cur.write;
            upper_byte_strobe_n <= ~(cur.addr[0] || (cur.word && !byte_mode));
            pins.lo_addr <= cur.addr[7:0];
            if (state == ext_bus_pkg::ST_HOLD) begin
                pins.mid_oe_n <= 8'hff;
                pins.hi_oe_n <= 8'hff;
            end else if (data_phase || state == ext_bus_pkg::ST_ADDR) begin
                // Strobe low: data on the lanes.
                pins.hi_out <= cur.wdata[7:0];
                pins.hi_oe_n <= {8{~drive_data}};
                if (byte_mode) begin
                    pins.mid_out <= cur.addr[15:8];
                    pins.mid_oe_n <= 8'h00;
                end else begin
                    pins.mid_out <= cur.wdata[15:8];
                    pins.mid_oe_n <= {8{~drive_data}};
                end
            end else begin
                // Strobe high: address on the lanes.
                pins.mid_out <= eff_addr[15:8];
                pins.hi_out <= eff_addr[23:16];
                pins.mid_oe_n <= 8'h00;
                pins.hi_oe_n <= 8'h00;
                pins.lo_addr <= eff_addr[7:0];
            end
        end
    end

    // Read data capture and the answer to the core.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_area <= 2'h0;
            req_ready <= 1'b0;
        end else begin
            rsp_valid <= (state == ext_bus_pkg::ST_DONE);
            req_ready <= (state == ext_bus_pkg::ST_IDLE && !hold_req);
            rsp_area <= area;
            if (state == ext_bus_pkg::ST_WAIT && !cur.write) begin
                if (area == ext_bus_pkg::AREA_RAM) begin
                    rsp_rdata <= {cur.word ? ram[ram_idx1] : 8'h00, ram[ram_idx]};
                end else if (area == ext_bus_pkg::AREA_EXT) begin
                    rsp_rdata <= {byte_mode ? 8'h00 : mid_in, hi_in};
                end else begin
                    rsp_rdata <= 16'h0000;
                end
            end
        end
    end

    // Divided clock output.
    clk_halver u_clk (
        .clk(clk),
        .arst_n(arst_n),
        .clk_out(clk_out)
    );

    // Assertions.
    sequence s_hold_seen;
        state == ext_bus_pkg::ST_HOLD;
    endsequence

    property p_grant;
        @(posedge clk) disable iff (!arst_n) s_hold_seen |=> !hold_grant_n;
    endproperty
    a_grant: assert property (p_grant) else $error("Hold grant not low in hold.");

    property p_grant_off;
        @(posedge clk) disable iff (!arst_n) state != ext_bus_pkg::ST_HOLD |=> hold_grant_n;
    endproperty
    a_grant_off: assert property (p_grant_off) else $error("Hold grant low outside hold.");

    property p_wait;
        @(posedge clk) disable iff (!arst_n)
            state == ext_bus_pkg::ST_WAIT && !ready_ok && area == ext_bus_pkg::AREA_EXT
            |=> state == ext_bus_pkg::ST_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("Cycle ended while not ready.");

    property p_hold_release;
        @(posedge clk) disable iff (!arst_n) state == ext_bus_pkg::ST_HOLD |=> pins.hi_oe_n == 8'hff;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("Lanes driven in hold.");

    property p_rw;
        @(posedge clk) disable iff (!arst_n) drive_data |=> !read_write && !strobe_n;
    endproperty
    a_rw: assert property (p_rw) else $error("Write without low read/write.");

    property p_odd;
        @(posedge clk) disable iff (!arst_n) state != ext_bus_pkg::ST_IDLE && cur.addr[0] |=> !upper_byte_strobe_n;
    endproperty
    a_odd: assert property (p_odd) else $error("Odd access without upper strobe.");

    sequence s_cycle;
        state == ext_bus_pkg::ST_ADDR ##1 state == ext_bus_pkg::ST_DATA;
    endsequence

    property p_strobe;
        @(posedge clk) disable iff (!arst_n) s_cycle |=> !strobe_n [*2];
    endproperty
    a_strobe: assert property (p_strobe) else $error("Strobe not low in cycle.");

    property p_byte_mid;
        @(posedge clk) disable iff (!arst_n) data_phase && byte_mode |=> pins.mid_oe_n == 8'h00;
    endproperty
    a_byte_mid: assert property (p_byte_mid) else $error("Middle lanes released in 8-bit mode.");

    // The latch pulse lasts one cycle; it falls on the same edge at which strobe goes low and the lanes turn to data.
    property p_latch_pulse;
        @(posedge clk) disable iff (!arst_n) addr_latch |=> !addr_latch && !strobe_n;
    endproperty
    a_latch_pulse: assert property (p_latch_pulse) else $error("Address latch pulse malformed.");

    // While the latch pulse stands, every lane is driven with the captured address.
    property p_addr_lanes;
        @(posedge clk) disable iff (!arst_n) addr_latch |->
            {pins.hi_out, pins.mid_out, pins.lo_addr} == cur.addr && pins.mid_oe_n == 8'h00 && pins.hi_oe_n == 8'h00;
    endproperty
    a_addr_lanes: assert property (p_addr_lanes) else $error("Address not on lanes at latch.");

    // A 16-bit write must put its high byte on the middle lanes.
    property p_word_mid;
        @(posedge clk) disable iff (!arst_n) drive_data && !byte_mode |=> pins.mid_oe_n == 8'h00;
    endproperty
    a_word_mid: assert property (p_word_mid) else $error("Middle lanes idle in 16-bit write.");

endmodule : ext_bus_unit

// ==== tb/ext_mem_model.sv ====
// External memory model on the multiplexed bus: latches addresses, answers reads, takes writes.
// Assumes the unit's bus outputs are registered and settle well before the next rising edge.
`timescale 1ns/1ps

module ext_mem_model (
    // Clock and test controls.
    input wire logic clk,
    input wire logic clr,
    input wire logic [3:0] wait_cyc,
    // Bus pins from the unit.
    input wire logic strobe_n,
    input wire logic addr_latch,
    input wire logic read_write,
    input wire ext_bus_pkg::bus_pins_s pins,
    // Answer pins and observations.
    output logic ready_n,
    output logic [7:0] mid_in,
    output logic [7:0] hi_in,
    output logic [23:0] m_addr,
    output logic [15:0] m_wd,
    output logic mid_bad
);
    logic [3:0] wcnt; // Strobe-low cycles seen in this access.

    initial begin
        {m_addr, m_wd, mid_bad, wcnt, mid_in, hi_in} = '0;
    end

    // Address is taken only while the latch strobe is up, as real latches would.
    always @(posedge clk) begin
        if (addr_latch) begin
            m_addr <= {pins.hi_out, pins.mid_out, pins.lo_addr};
            wcnt <= '0;
        end else if (!strobe_n) begin
            wcnt <= wcnt + 4'h1;
            if (!read_write && !pins.hi_oe_n[0]) begin
                m_wd[7:0] <= pins.hi_out;
            end
            if (!read_write && !pins.mid_oe_n[0]) begin
                m_wd[15:8] <= pins.mid_out;
            end
            // Middle lanes driven with anything but the address; only meaningful in 8-bit mode.
            if (!pins.mid_oe_n[0] && pins.mid_out != m_addr[15:8]) begin
                mid_bad <= 1'b1;
            end
        end
        if (clr) begin
            mid_bad <= 1'b0;
        end
    end

    // A slow memory holds ready low for wait_cyc strobe-low cycles of each access.
    // It pulls ready low already during the latch pulse, since the unit sees ready two flops late.
    assign ready_n = ((addr_latch && wait_cyc != 4'h0) || (!strobe_n && wcnt < wait_cyc)) ? 1'b0 : 1'b1;

    // Read data only while strobe is low on a read; otherwise the lanes toggle,
    // so a unit sampling outside the window sees garbage, not stale data.
    always @(negedge clk) begin
        if (!strobe_n && read_write) begin
            mid_in <= m_addr[7:0] ^ 8'h5a;
            hi_in <= m_addr[15:8];
        end else begin
            mid_in <= ~mid_in;
            hi_in <= ~hi_in;
        end
    end
endmodule : ext_mem_model

// ==== tb/tb_ext_bus_unit.sv ====
// Self-checking bench for the external bus unit with a memory model on its pins.
// Assumes the unit's contract: one access at a time, five-cycle answer without waits.
`timescale 1ns/1ps

module tb_ext_bus_unit;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    ext_bus_pkg::bus_req_s req = '0;
    logic [7:0] code_bank = 8'h00;
    logic [15:0] instr_pointer = 16'h0000;
    logic width_sel = 1'b0;
    logic hold_n = 1'b1;
    logic clr = 1'b0;
    logic [3:0] wait_cyc = 4'h0;
    logic req_ready, rsp_valid, strobe_n, addr_latch, read_write, ub_n, grant_n, clk_out, ready_n, mid_bad;
    logic [15:0] rsp_rdata, m_wd;
    logic [1:0] rsp_area;
    logic [7:0] mid_in, hi_in;
    logic [23:0] m_addr;
    ext_bus_pkg::bus_pins_s pins;
    int error_cnt = 0;
    int cmp_count = 0;
    int lat; // Cycles from take to answer.
    logic rw, ub; // Direction and upper strobe seen while strobe was low.

    always #25 clk = ~clk;

    ext_bus_unit dut_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .code_bank(code_bank),
        .instr_pointer(instr_pointer), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_area(rsp_area), .width_sel(width_sel), .ready_n(ready_n), .hold_n(hold_n), .mid_in(mid_in),
        .hi_in(hi_in), .pins(pins), .strobe_n(strobe_n), .addr_latch(addr_latch), .read_write(read_write),
        .upper_byte_strobe_n(ub_n), .hold_grant_n(grant_n), .clk_out(clk_out));

    ext_mem_model mem_u (.clk(clk), .clr(clr), .wait_cyc(wait_cyc), .strobe_n(strobe_n),
        .addr_latch(addr_latch), .read_write(read_write), .pins(pins), .ready_n(ready_n), .mid_in(mid_in),
        .hi_in(hi_in), .m_addr(m_addr), .m_wd(m_wd), .mid_bad(mid_bad));

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One access: request held until taken, then wait for the answer, noting strobe-low pins.
    task automatic acc(input logic w, input logic wd, input logic f, input logic [23:0] a, input logic [15:0] d);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{write: w, word: wd, fetch: f, addr: a, wdata: d};
        for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
            @(negedge clk);
        end
        @(negedge clk);
        req_valid = 1'b0;
        // The take is edge 0; lat ends as the number of the edge at which the answer is sampled.
        for (lat = 2; lat < 40; lat++) begin
            @(negedge clk);
            if (strobe_n === 1'b0) begin
                rw = read_write;
                ub = ub_n;
            end
            if (rsp_valid === 1'b1) break;
        end
        chk(rsp_valid, 1'b1);
    endtask : acc

    task automatic t_ext;
        acc(0, 1, 0, 24'h123457, 16'h0000);
        chk(m_addr, 24'h123457);
        chk(rsp_rdata, 16'h0d34);
        chk(rw, 1'b1);
        chk(ub, 1'b0);
        chk(rsp_area, 2'h2);
        chk(lat, 5);
        acc(1, 1, 0, 24'h401000, 16'hbeef);
        chk(m_wd, 16'hbeef);
        chk(rw, 1'b0);
        $display("test ext done");
    endtask : t_ext

    task automatic t_byte;
        width_sel = 1'b1;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        acc(1, 0, 0, 24'h002001, 16'h77a5);
        chk(m_wd[7:0], 8'ha5);
        chk(mid_bad, 1'b0);
        chk(ub, 1'b0);
        acc(0, 0, 0, 24'h003002, 16'h0000);
        chk(rsp_rdata[7:0], 8'h30);
        chk(ub, 1'b1);
        width_sel = 1'b0;
        $display("test byte done");
    endtask : t_byte

    task automatic t_wait;
        wait_cyc = 4'h4;
        acc(0, 1, 0, 24'h020010, 16'h0000);
        chk(lat >= 9 && lat <= 12, 1'b1);
        chk(rsp_rdata, 16'h4a00);
        wait_cyc = 4'h0;
        $display("test wait done");
    endtask : t_wait

    task automatic t_areas;
        logic [23:0] adr [6] = '{24'h000000, 24'h00007f, 24'h000080, 24'h00047f, 24'h000480, 24'h010010};
        logic [1:0] ea [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 6; i++) begin
            acc(0, 0, 0, adr[i], 16'h0000);
            chk(rsp_area, ea[i]);
            chk(m_addr, adr[i]);
        end
        acc(0, 1, 0, 24'h000010, 16'h0000);
        chk(rsp_rdata, 16'h0000);
        acc(1, 1, 0, 24'h000100, 16'h1234);
        acc(0, 1, 0, 24'h000100, 16'h0000);
        chk(rsp_rdata, 16'h1234);
        acc(0, 1, 0, 24'h00fffe, 16'h0000);
        chk(rsp_area, 2'h2);
        chk(rsp_rdata, 16'ha4ff);
        code_bank = 8'h3c;
        instr_pointer = 16'hbee0;
        acc(0, 1, 1, 24'h000000, 16'h0000);
        chk(m_addr, 24'h3cbee0);
        $display("test areas done");
    endtask : t_areas

    task automatic t_hold;
        @(negedge clk);
        hold_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(grant_n, 1'b0);
        chk(strobe_n, 1'b1);
        chk({pins.mid_oe_n, pins.hi_oe_n}, 16'hffff);
        req_valid = 1'b1;
        req = '{write: 1'b0, word: 1'b1, fetch: 1'b0, addr: 24'h050020, wdata: 16'h0000};
        repeat (6) @(negedge clk);
        chk(req_ready, 1'b0);
        chk(grant_n, 1'b0);
        hold_n = 1'b1;
        acc(0, 1, 0, 24'h050020, 16'h0000);
        chk(rsp_rdata, 16'h7a00);
        chk(grant_n, 1'b1);
        $display("test hold done");
    endtask : t_hold

    task automatic t_clk_rst;
        logic prev;
        prev = clk_out;
        repeat (4) begin
            @(negedge clk);
            chk(clk_out, !prev);
            prev = clk_out;
        end
        req_valid = 1'b1;
        req = '{write: 1'b1, word: 1'b1, fetch: 1'b0, addr: 24'h060000, wdata: 16'h5555};
        repeat (3) @(negedge clk);
        arst_n = 1'b0;
        req_valid = 1'b0;
        #1;
        chk({strobe_n, grant_n, addr_latch, pins.hi_oe_n}, {3'b110, 8'hff});
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        acc(0, 1, 0, 24'h070102, 16'h0000);
        chk(rsp_rdata, 16'h5801);
        $display("test clock and reset done");
    endtask : t_clk_rst

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Watchdog: all tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_ext();
        t_byte();
        t_wait();
        t_areas();
        t_hold();
        t_clk_rst();
        close_out();
    end
endmodule : tb_ext_bus_unit
